// [hw/spi_cfg_pkg.sv]
// Summary of operation
// RL1: busy bit 7 high during transfer
// RL2: bit 6 selects master or slave role
// RL3: bit 5 picks first or second sampling edge
// RL4: bit 4 sets serial clock idle level
// RL5: bit 3 reads 1 while select low
// RL6: selected flag follows filtered select input
// RL7: bit 2 returns raw select pin level
// RL8: slave shifter-empty sets when all data done
// RL9: shifter-empty clears on load or leading clock edge
// RL10: shifter-empty reads 1 in master role
// RL11: slave rx-empty reads 1 when drained
// RL12: slave rx-empty reads 0 with unread byte
// RL13: rx-empty reads 1 in master role
// RL14: slave samples data at bit centre
// RL15: master samples one cycle before bit end
// RL16: four-wire slave ignores bus while deselected
// RL17: status bits ignore writes, config bits store
package spi_cfg_pkg;

  localparam logic [7:0] CFG_ADDR        = 8'hA1;
  localparam int         BIT_BUSY        = 7;
  localparam int         BIT_MASTER      = 6;
  localparam int         BIT_PHASE       = 5;
  localparam int         BIT_POLARITY    = 4;
  localparam int         BIT_SELECTED    = 3;
  localparam int         BIT_RAW_SEL     = 2;
  localparam int         BIT_SHIFT_EMPTY = 1;
  localparam int         BIT_RX_EMPTY    = 0;
  localparam logic [7:0] CFG_RESET       = 8'h07;

  localparam int         DATA_W          = 8;
  localparam int         SYS_CLK_HZ      = 40000000;
  localparam int         MASTER_SCK_HZ   = 5000000;
  // half serial clock period in system clocks, at least two
  localparam int         HALF_CYC        = SYS_CLK_HZ / (2 * MASTER_SCK_HZ);
  localparam logic [7:0] HALF_LAST       = 8'(HALF_CYC - 1);
  localparam logic [7:0] HALF_SAMPLE     = 8'(HALF_CYC - 2);
  // select must hold this many cycles before the flag follows
  localparam logic [2:0] SEL_FILT_CYC    = 3'h3;

endpackage : spi_cfg_pkg

// [hw/spi_rx_buffer.sv]
`timescale 1ns/1ps
module spi_rx_buffer
  import spi_cfg_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // fill side
  input  wire logic              in_valid_i,
  output logic                   in_ready_o,
  input  wire logic [DATA_W-1:0] in_data_i,
  // drain side
  output logic                   out_valid_o,
  input  wire logic              out_ready_i,
  output logic [DATA_W-1:0]      out_data_o
);

  logic              head_v_r;
  logic              tail_v_r;
  logic [DATA_W-1:0] tail_d_r;
  logic              push;
  logic              pop;

  // head entry drives the outputs directly so they stay registered
  assign in_ready_o = ~tail_v_r;
  assign push       = in_valid_i & ~tail_v_r;
  assign pop        = head_v_r & out_ready_i;
  assign out_valid_o = head_v_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      head_v_r   <= 1'b0;
      tail_v_r   <= 1'b0;
      tail_d_r   <= 8'h00;
      out_data_o <= 8'h00;
    end else if (pop) begin
      if (tail_v_r) begin
        out_data_o <= tail_d_r;
        tail_v_r   <= push;
        if (push) begin
          tail_d_r <= in_data_i;
        end
      end else if (push) begin
        out_data_o <= in_data_i;
      end else begin
        head_v_r <= 1'b0;
      end
    end else if (push) begin
      if (!head_v_r) begin
        out_data_o <= in_data_i;
        head_v_r   <= 1'b1;
      end else begin
        tail_d_r <= in_data_i;
        tail_v_r <= 1'b1;
      end
    end
  end

endmodule : spi_rx_buffer

// [hw/spi_config_status_register.sv]
`timescale 1ns/1ps
module spi_config_status_register
  import spi_cfg_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // special-function register bus
  input  wire logic [7:0]        sfr_addr_i,
  input  wire logic              sfr_wr_i,
  input  wire logic              sfr_rd_i,
  input  wire logic [7:0]        sfr_wdata_i,
  output logic [7:0]             sfr_rdata_o,
  // transmit byte stream
  input  wire logic              tx_valid_i,
  output logic                   tx_ready_o,
  input  wire logic [DATA_W-1:0] tx_data_i,
  // receive byte stream
  output logic                   rx_valid_o,
  input  wire logic              rx_ready_i,
  output logic [DATA_W-1:0]      rx_data_o,
  // link pins
  input  wire logic              sck_i,
  input  wire logic              mosi_i,
  input  wire logic              miso_i,
  input  wire logic              slave_select_n_i,
  output logic                   sck_o,
  output logic                   sck_oe_n_o,
  output logic                   mosi_o,
  output logic                   mosi_oe_n_o,
  output logic                   miso_o,
  output logic                   miso_oe_n_o
);

  typedef enum logic {M_IDLE, M_SHIFT} mstate_t;

  // configuration
  logic              master_role_enable_r;
  logic              clock_phase_sel_r;
  logic              clock_polarity_sel_r;
  // synchronisers
  logic [2:0]        sck_s_r;
  logic [1:0]        mosi_s_r;
  logic [1:0]        miso_s_r;
  logic [1:0]        nss_s_r;
  logic [2:0]        filt_cnt_r;
  logic              slave_selected_filtered_r;
  logic              sel_prev_r;
  // shifter
  mstate_t           mstate_r;
  logic [7:0]        half_cnt_r;
  logic              half_r;
  logic [2:0]        bits_r;
  logic [7:0]        shreg_r;
  logic [7:0]        shreg_nxt;
  logic              out_bit_r;
  logic              transfer_busy_r;
  logic              shifter_empty_r;
  // derived events
  logic              cfg_hit_wr;
  logic              cfg_hit_rd;
  logic              sck_edge;
  logic              lead_edge;
  logic              trail_edge;
  logic              slave_on;
  logic              s_sample;
  logic              s_shift;
  logic              m_sample;
  logic              bit_end;
  logic              bit_adv;
  logic              byte_done;
  logic              load;
  logic              m_start;
  logic              in_bit;
  logic              rx_push;
  logic              rx_in_ready;
  logic [7:0]        status;

  assign cfg_hit_wr = sfr_wr_i && (sfr_addr_i == CFG_ADDR);
  assign cfg_hit_rd = sfr_rd_i && (sfr_addr_i == CFG_ADDR);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      master_role_enable_r <= CFG_RESET[BIT_MASTER];
      clock_phase_sel_r    <= CFG_RESET[BIT_PHASE];
      clock_polarity_sel_r <= CFG_RESET[BIT_POLARITY];
    end else if (cfg_hit_wr) begin
      master_role_enable_r <= sfr_wdata_i[BIT_MASTER];                 // RL2
      clock_phase_sel_r    <= sfr_wdata_i[BIT_PHASE];                  // RL17
      clock_polarity_sel_r <= sfr_wdata_i[BIT_POLARITY];
    end
  end

  // all pins cross from outside the clock domain
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_s_r  <= 3'h0;
      mosi_s_r <= 2'h0;
      miso_s_r <= 2'h0;
      nss_s_r  <= 2'h3;
    end else begin
      sck_s_r  <= {sck_s_r[1:0], sck_i};
      mosi_s_r <= {mosi_s_r[0], mosi_i};
      miso_s_r <= {miso_s_r[0], miso_i};
      nss_s_r  <= {nss_s_r[0], slave_select_n_i};
    end
  end

  // glitch filter: flag moves only after a stable run of samples
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      filt_cnt_r                <= 3'h0;
      slave_selected_filtered_r <= CFG_RESET[BIT_SELECTED];
      sel_prev_r                <= 1'b0;
    end else begin
      sel_prev_r <= slave_selected_filtered_r;
      if (nss_s_r[1] != slave_selected_filtered_r) begin
        filt_cnt_r <= 3'h0;                                              // RL6
      end else if (filt_cnt_r == SEL_FILT_CYC - 3'h1) begin
        filt_cnt_r                <= 3'h0;
        slave_selected_filtered_r <= ~nss_s_r[1];                       // RL5
      end else begin
        filt_cnt_r <= filt_cnt_r + 3'h1;
      end
    end
  end

  // slave edges, qualified by select; lead leaves the idle level
  assign slave_on   = !master_role_enable_r && slave_selected_filtered_r; // RL16
  assign sck_edge   = slave_on && (sck_s_r[2] != sck_s_r[1]);
  assign lead_edge  = sck_edge && (sck_s_r[1] != clock_polarity_sel_r);
  assign trail_edge = sck_edge && (sck_s_r[1] == clock_polarity_sel_r);
  assign s_sample   = clock_phase_sel_r ? trail_edge : lead_edge;       // RL14
  assign s_shift    = clock_phase_sel_r ? lead_edge : trail_edge;       // RL3

  // master timing: sample one clock before the bit period closes
  assign m_sample = (mstate_r == M_SHIFT) && half_r && (half_cnt_r == HALF_SAMPLE); // RL15
  assign bit_end  = (mstate_r == M_SHIFT) && half_r && (half_cnt_r == HALF_LAST);

  assign bit_adv   = master_role_enable_r ? bit_end : s_sample;
  assign byte_done = bit_adv && (bits_r == 3'h7);
  assign in_bit    = master_role_enable_r ? miso_s_r[1] : mosi_s_r[1];
  assign m_start   = (mstate_r == M_IDLE) && master_role_enable_r && tx_valid_i && tx_ready_o;
  assign load      = tx_valid_i && tx_ready_o;
  assign rx_push   = byte_done;

  always_comb begin
    shreg_nxt = shreg_r;
    if (load) begin
      shreg_nxt = tx_data_i;
    end else if (master_role_enable_r ? m_sample : s_sample) begin
      shreg_nxt = {shreg_r[6:0], in_bit};
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mstate_r   <= M_IDLE;
      half_cnt_r <= 8'h00;
      half_r     <= 1'b0;
    end else begin
      case (mstate_r)
        M_IDLE: begin
          half_cnt_r <= 8'h00;
          half_r     <= 1'b0;
          if (m_start) begin
            mstate_r <= M_SHIFT;
          end
        end
        M_SHIFT: begin
          if (half_cnt_r == HALF_LAST) begin
            half_cnt_r <= 8'h00;
            half_r     <= ~half_r;
          end else begin
            half_cnt_r <= half_cnt_r + 8'h01;
          end
          if (byte_done || !master_role_enable_r) begin
            mstate_r <= M_IDLE;
          end
        end
        default: mstate_r <= M_IDLE;
      endcase
    end
  end

  // bit counter restarts when the slave becomes selected
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bits_r <= 3'h0;
    end else if (m_start || (slave_selected_filtered_r && !sel_prev_r)) begin
      bits_r <= 3'h0;
    end else if (bit_adv) begin
      bits_r <= bits_r + 3'h1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shreg_r   <= 8'h00;
      out_bit_r <= 1'b0;
    end else begin
      shreg_r <= shreg_nxt;
      if (load || (master_role_enable_r ? bit_end : s_shift)) begin
        out_bit_r <= shreg_nxt[7];
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      transfer_busy_r <= CFG_RESET[BIT_BUSY];
    end else if (byte_done || (!master_role_enable_r && !slave_on)) begin
      transfer_busy_r <= 1'b0;                                          // RL1
    end else if (m_start || lead_edge) begin
      transfer_busy_r <= 1'b1;
    end
  end

  // end of byte wins over a leading edge, a load wins over end of byte; only a leading edge opens a bit, so the trailing edge
  // that closes the last phase-0 bit cannot leave the shifter looking full
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shifter_empty_r <= CFG_RESET[BIT_SHIFT_EMPTY];
    end else if (byte_done && !load) begin
      shifter_empty_r <= 1'b1;                                          // RL8
    end else if (load || lead_edge) begin
      shifter_empty_r <= 1'b0;                                          // RL9
    end
  end

  // in master role accepting a byte needs room downstream, so a stalled reader stalls the master
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_ready_o <= 1'b0;
    end else if (load) begin
      tx_ready_o <= 1'b0;
    end else if (master_role_enable_r) begin
      tx_ready_o <= (mstate_r == M_IDLE) && rx_in_ready;
    end else begin
      tx_ready_o <= shifter_empty_r && !transfer_busy_r;
    end
  end

  spi_rx_buffer u_rx_buffer (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (shreg_nxt),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

  // pins: master drives clock and data out, slave drives its reply only when selected
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_o       <= 1'b0;
      sck_oe_n_o  <= 1'b1;
      mosi_o      <= 1'b0;
      mosi_oe_n_o <= 1'b1;
      miso_o      <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end else begin
      if (mstate_r == M_SHIFT) begin
        sck_o <= clock_polarity_sel_r ^ (clock_phase_sel_r ? ~half_r : half_r); // RL3
      end else begin
        sck_o <= clock_polarity_sel_r;                                    // RL4
      end
      sck_oe_n_o  <= ~master_role_enable_r;
      mosi_o      <= out_bit_r;
      mosi_oe_n_o <= ~master_role_enable_r;
      miso_o      <= out_bit_r;
      miso_oe_n_o <= ~slave_on;                                           // RL16
    end
  end

  always_comb begin
    status                  = 8'h00;
    status[BIT_BUSY]        = transfer_busy_r;
    status[BIT_MASTER]      = master_role_enable_r;
    status[BIT_PHASE]       = clock_phase_sel_r;
    status[BIT_POLARITY]    = clock_polarity_sel_r;
    status[BIT_SELECTED]    = slave_selected_filtered_r;
    status[BIT_RAW_SEL]     = nss_s_r[1];                                 // RL7
    status[BIT_SHIFT_EMPTY] = master_role_enable_r | shifter_empty_r;     // RL10
    status[BIT_RX_EMPTY]    = master_role_enable_r | ~rx_valid_o;         // RL11 RL12 RL13
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (cfg_hit_rd) begin
      sfr_rdata_o <= status;                                              // RL13
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  a_busy_read: assert property (@(posedge clk_i) disable iff (reset_i) // RL1
    cfg_hit_rd |=> sfr_rdata_o[BIT_BUSY] == $past(transfer_busy_r))
    else $error("busy bit does not match transfer state");

  a_cfg_store: assert property (@(posedge clk_i) disable iff (reset_i) // RL17
    cfg_hit_wr |=> {master_role_enable_r, clock_phase_sel_r, clock_polarity_sel_r}
                   == $past(sfr_wdata_i[6:4]))
    else $error("configuration write not stored");

  a_master_empty: assert property (@(posedge clk_i) disable iff (reset_i) // RL10
    (cfg_hit_rd && master_role_enable_r) |=> (sfr_rdata_o[1:0] == 2'h3))
    else $error("empty bits not forced in master role");

  a_sel_filter: assert property (@(posedge clk_i) disable iff (reset_i) // RL6
    $rose(slave_selected_filtered_r) |-> $past(!nss_s_r[1], 2) && $past(!nss_s_r[1], 3))
    else $error("selected flag rose without stable select");

  a_slave_ignore: assert property (@(posedge clk_i) disable iff (reset_i) // RL16
    (!master_role_enable_r && !slave_selected_filtered_r) |-> !s_sample && !sck_edge)
    else $error("deselected slave reacted to clock");

  a_raw_read: assert property (@(posedge clk_i) disable iff (reset_i) // RL7
    cfg_hit_rd |=> sfr_rdata_o[BIT_RAW_SEL] == $past(nss_s_r[1]))
    else $error("raw select bit wrong");

  a_load_clears: assert property (@(posedge clk_i) disable iff (reset_i) // RL9
    (load && !byte_done) |=> !shifter_empty_r)
    else $error("load did not clear shifter empty");

  a_master_sample: assert property (@(posedge clk_i) disable iff (reset_i) // RL15
    m_sample |=> bit_end)
    else $error("master sample not one cycle before bit end");

  a_idle_level: assert property (@(posedge clk_i) disable iff (reset_i) // RL4
    (mstate_r == M_IDLE && $stable(clock_polarity_sel_r)) |=> sck_o == $past(clock_polarity_sel_r))
    else $error("clock idle level wrong");

  a_rx_pending: assert property (@(posedge clk_i) disable iff (reset_i) // RL12
    (cfg_hit_rd && !master_role_enable_r && rx_valid_o) |=> !sfr_rdata_o[BIT_RX_EMPTY])
    else $error("rx empty set with unread byte");

endmodule : spi_config_status_register

// [bench/spi_far_model.sv]
`timescale 1ns/1ps
module spi_far_model (
  // wires as seen on the link
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic miso_i,
  // far side drive
  output logic      sck_o,
  output logic      mosi_o,
  output logic      miso_o,
  output logic      slave_select_n_o,
  // far side role and mode
  input  wire logic slave_role_i,
  input  wire logic cpol_i,
  input  wire logic cpha_i
);
  logic [7:0] shift_r;
  logic [7:0] seen_r;

  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    miso_o = 1'b0;
    slave_select_n_o = 1'b1;
    shift_r = 8'h00;
    seen_r = 8'h00;
  end

  task automatic drive_sel(input logic lvl);
    slave_select_n_o = lvl;
  endtask : drive_sel

  // acting as master: 200 ns per bit, clock stands still outside frames
  task automatic frame(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
    int i;
    sck_o = cpol_i;
    // keep every link change off the design's sampling edge
    #110;
    slave_select_n_o = !sel;
    #250;
    for (i = 7; i >= 0; i--) begin
      if (cpha_i) sck_o = !cpol_i;
      mosi_o = tx[i];
      #100;
      sck_o = cpha_i ? cpol_i : !cpol_i;
      rx[i] = miso_i;
      #100;
      if (!cpha_i) sck_o = cpol_i;
    end
    #150;
    // released line must not keep showing the last bit
    mosi_o = !mosi_o;
    slave_select_n_o = 1'b1;
    #250;
  endtask : frame

  task automatic arm(input logic [7:0] s);
    shift_r = s;
    miso_o = s[7];
  endtask : arm

  // acting as slave behind a master design
  always @(sck_i) begin
    if (slave_role_i) begin
      if (sck_i != cpol_i) begin
        if (cpha_i) begin
          miso_o = shift_r[7];
          shift_r = {shift_r[6:0], !shift_r[0]};
        end else begin
          seen_r = {seen_r[6:0], mosi_i};
        end
      end else begin
        if (cpha_i) begin
          seen_r = {seen_r[6:0], mosi_i};
        end else begin
          shift_r = {shift_r[6:0], !shift_r[0]};
          miso_o = shift_r[7];
        end
      end
    end
  end
endmodule : spi_far_model

// [bench/spi_config_status_register_tb.sv]
`timescale 1ns/1ps
module spi_config_status_register_tb;
  import spi_cfg_pkg::*;
  logic       clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] tx_data_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic       sfr_rd_i = 1'b0;
  logic       tx_valid_i = 1'b0;
  logic       rx_ready_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic [7:0] rx_data_o;
  logic       tx_ready_o, rx_valid_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o;
  logic       miso_o, miso_oe_n_o, f_sck, f_mosi, f_miso, f_sel_n, sck_w, mosi_w, miso_w;
  logic       role_r = 1'b0;
  logic       cpol_r = 1'b0;
  logic       cpha_r = 1'b0;
  logic       hold_r = 1'b1;
  logic       rd_seen = 1'b0;
  logic [7:0] rd_q[$];
  logic [7:0] rx_q[$];
  int         failures = 0;
  int         checks_done = 0;

  // enable low means the design owns the wire
  assign sck_w  = sck_oe_n_o  ? f_sck  : sck_o;
  assign mosi_w = mosi_oe_n_o ? f_mosi : mosi_o;
  assign miso_w = miso_oe_n_o ? f_miso : miso_o;

  spi_config_status_register dut (
    .clk_i, .reset_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
    .tx_valid_i, .tx_ready_o, .tx_data_i, .rx_valid_o, .rx_ready_i, .rx_data_o,
    .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .slave_select_n_i(f_sel_n),
    .sck_o, .sck_oe_n_o, .mosi_o, .mosi_oe_n_o, .miso_o, .miso_oe_n_o);

  spi_far_model far (
    .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(f_sck), .mosi_o(f_mosi),
    .miso_o(f_miso), .slave_select_n_o(f_sel_n), .slave_role_i(role_r),
    .cpol_i(cpol_r), .cpha_i(cpha_r));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) rx_ready_i <= hold_r ? 1'b0 : 1'($urandom % 2);

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  always @(posedge clk_i) begin
    if (rd_seen) chk("status", rd_q.pop_front(), sfr_rdata_o);
    rd_seen <= sfr_rd_i;
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
      chk("rx byte", rx_q.size() ? rx_q.pop_front() : 8'hXX, rx_data_o);
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    rd_q.push_back(exp);
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : rd

  task automatic send_tx(input logic [7:0] d);
    int i;
    tx_data_i <= d;
    tx_valid_i <= 1'b1;
    @(posedge clk_i);
    for (i = 0; i < 300 && tx_ready_o !== 1'b1; i++) @(posedge clk_i);
    tx_valid_i <= 1'b0;
  endtask : send_tx

  task automatic wait_drain();
    int i;
    for (i = 0; i < 400 && (rx_q.size() != 0 || rx_valid_o !== 1'b0); i++) @(posedge clk_i);
    chk("rx left", 8'h00, 8'(rx_q.size()));
  endtask : wait_drain

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #2000000;
    failures++;
    print_verdict();
  end

  initial begin
    logic [7:0] t, m, s, c;
    int k, i;
    void'($urandom(32'h73F88E59));
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(CFG_ADDR, CFG_RESET);
    wr(CFG_ADDR, 8'hFF);
    rd(CFG_ADDR, 8'h77);
    wr(CFG_ADDR, 8'h00);
    rd(8'hA0, 8'h00);
    $display("test registers done");
    // two-sample glitch: the synchroniser sees it, the filter must not
    #3 far.drive_sel(1'b0);
    #50 far.drive_sel(1'b1);
    rd(CFG_ADDR, 8'h03);
    #3 far.drive_sel(1'b0);
    repeat (10) @(posedge clk_i);
    rd(CFG_ADDR, 8'h0B);
    #3 far.drive_sel(1'b1);
    repeat (10) @(posedge clk_i);
    $display("test select done");
    for (k = 0; k < 4; k++) begin
      c = {2'b00, k[1:0], 4'h0};
      cpha_r = k[1];
      cpol_r = k[0];
      wr(CFG_ADDR, c | 8'h8F);
      rd(CFG_ADDR, c | 8'h07);
      t = 8'($urandom);
      m = 8'($urandom);
      send_tx(t);
      rd(CFG_ADDR, c | 8'h05);
      rx_q.push_back(m);
      far.frame(m, 1'b1, s);
      repeat (10) @(posedge clk_i);
      rd(CFG_ADDR, c | 8'h06);
      chk("miso byte", t, s);
      hold_r = 1'b0;
      wait_drain();
      rd(CFG_ADDR, c | 8'h07);
      hold_r = 1'b1;
      far.frame(8'hA5, 1'b0, s);
      repeat (10) @(posedge clk_i);
      chk("rx while deselected", 8'h00, {7'h00, rx_valid_o});
      chk("miso enable deselected", 8'h01, {7'h00, miso_oe_n_o});
    end
    $display("test slave modes done");
    wr(CFG_ADDR, 8'h00);
    cpha_r = 1'b0;
    cpol_r = 1'b0;
    // third byte meets a full buffer and is dropped
    for (k = 0; k < 3; k++) begin
      m = 8'($urandom);
      if (k < 2) rx_q.push_back(m);
      far.frame(m, 1'b1, s);
    end
    rd(CFG_ADDR, 8'h06);
    hold_r = 1'b0;
    wait_drain();
    hold_r = 1'b1;
    $display("test buffer full done");
    for (k = 0; k < 4; k++) begin
      c = {2'b01, k[1:0], 4'h0};
      cpha_r = k[1];
      cpol_r = k[0];
      wr(CFG_ADDR, c);
      repeat (4) @(posedge clk_i);
      t = 8'($urandom);
      s = 8'($urandom);
      role_r = 1'b1;
      far.arm(s);
      rx_q.push_back(s);
      send_tx(t);
      repeat (3) @(posedge clk_i);
      rd(CFG_ADDR, c | 8'h87);
      for (i = 0; i < 300 && rx_valid_o !== 1'b1; i++) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      rd(CFG_ADDR, c | 8'h07);
      chk("mosi byte", t, far.seen_r);
      hold_r = 1'b0;
      wait_drain();
      hold_r = 1'b1;
      role_r = 1'b0;
    end
    $display("test master modes done");
    print_verdict();
  end
endmodule : spi_config_status_register_tb
